// [design/psq_sequencer.sv]
`default_nettype none
// Overview of operation
// - 14-bit program counter addresses one 16-bit word of 16K program memory.
// - reset or taken interrupt loads its vector straight into the counter.
// - reset starts at zero; vectors reserve 0 to 23h; code starts at 24h.
// - eight vectors 4h..20h, divider0 first down to timer1 last.
// - sixteen-entry last-in first-out context stack, each entry 51 bits.
// - call or interrupt pushes pc and all context registers in one entry.
// - plain return pops pc only; immediate return restores selected registers.
// - bit0 table nibbles, bit1 banks, bits2..6 wrp, rom page, ram page, acc, cf.
// - pushing beyond sixteen overwrites oldest entry, no overflow error.
// - program memory is eight pages of 2K words.
// - conditional branches and skips stay in the current page.
// - 4-bit table elements, 16-bit address from four nibbles, word address times four.
// - table read fetches the selected element and stores it to RAM.
// - page register 4 bits, bit 3 reserved, bits 2..0 pick page 0..7.
// - page register is write-only, never read back.
// - direct addressing takes all 14 pc bits from the instruction.
// - far jump or call: bits 13..11 from page register, 10..0 from instruction.
module psq_sequencer (
	// clock and reset
	input  wire logic                          mclk_in,
	input  wire logic                          rst_n_in,
	// decoder request
	input  wire psq_pkg::psq_req_t             req_in,
	// context written by the core's data path
	input  wire psq_pkg::psq_ctx_t             core_ctx_in,
	// interrupt requests, bit 0 highest priority
	input  wire logic [psq_pkg::NUM_IRQ-1:0]   irq_req_in,
	// program rom
	output logic [psq_pkg::PC_W-1:0]           rom_addr_out,
	input  wire logic [psq_pkg::INSN_W-1:0]    rom_data_in,
	// table element read
	output logic [psq_pkg::TAB_W-1:0]          table_addr_out,
	output logic [psq_pkg::NIB_W-1:0]          table_data_out,
	output logic                               table_data_valid_out,
	// interrupt acknowledge
	output logic [psq_pkg::NUM_IRQ-1:0]        irq_ack_out,
	// context restore towards the core
	output psq_pkg::psq_ctx_t                  restore_ctx_out,
	output logic [psq_pkg::SEL_W-1:0]          restore_sel_out,
	output logic                               restore_valid_out,
	// current page and counter
	output logic [psq_pkg::PAGE_W-1:0]         rom_page_out,
	output logic [psq_pkg::PC_W-1:0]           pc_out
);
	import psq_pkg::*;

	typedef enum logic [1:0] {
		ST_RESET = 2'b01,
		ST_RUN   = 2'b10
	} psq_state_t;

	typedef struct packed {
		psq_state_t          st;
		logic [PC_W-1:0]     pc;
		logic [NIB_W-1:0]    page_reg;
		logic                tab_pend;
		logic [TAB_W-1:0]    tab_addr;
		logic [NIB_W-1:0]    tab_data;
		logic                tab_valid;
		logic [NUM_IRQ-1:0]  ack;
		psq_ctx_t            rctx;
		logic [SEL_W-1:0]    rsel;
		logic                rvalid;
	} psq_seq_state_t;

	psq_seq_state_t s_q;
	psq_seq_state_t s_d;

	logic      push;
	logic      pop;
	psq_ctx_t  push_ctx;
	psq_ctx_t  top;
	logic      irq_any;
	logic [2:0] irq_idx;
	logic [PC_W-1:0] pc_inc;
	logic [TAB_W-1:0] tab_now;

	// highest priority pending request wins
	always_comb begin
		irq_any = 1'b0;
		irq_idx = '0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (irq_req_in[i]) begin
				irq_any = 1'b1;
				irq_idx = 3'(i);
			end
		end
	end

	assign pc_inc = s_q.pc + 1'b1;
	// table address from the four nibbles
	assign tab_now = {core_ctx_in.table_addr_nibble3,
		core_ctx_in.table_addr_nibble2,
		core_ctx_in.table_addr_nibble1,
		core_ctx_in.table_addr_nibble0};

	// context to push: live core registers plus pc and page
	always_comb begin
		push_ctx = core_ctx_in;
		push_ctx.rom_page_select = s_q.page_reg[PAGE_W-1:0];
		push_ctx.pc = pc_inc;
		push = 1'b0;
		pop = 1'b0;
		if (s_q.st == ST_RUN && irq_any) begin
			push = 1'b1;
			push_ctx.pc = s_q.pc;
		end else if (s_q.st == ST_RUN && req_in.valid
			&& req_in.op == PSQ_OP_CALL) begin
			push = 1'b1;
		end else if (s_q.st == ST_RUN && req_in.valid
			&& (req_in.op == PSQ_OP_RET
			|| req_in.op == PSQ_OP_RETSEL)) begin
			pop = 1'b1;
		end
	end

	// next state of the sequencer
	always_comb begin
		s_d = s_q;
		s_d.ack = '0;
		s_d.rvalid = 1'b0;
		s_d.tab_valid = 1'b0;
		// finish table read one cycle after the address went out
		if (s_q.tab_pend) begin
			s_d.tab_pend = 1'b0;
			s_d.tab_valid = 1'b1;
			s_d.tab_data = rom_data_in[s_q.tab_addr[1:0]*NIB_W +: NIB_W];
		end
		case (s_q.st)
			ST_RESET: begin
				s_d.pc = RESET_VECTOR;
				s_d.st = ST_RUN;
			end
			ST_RUN: begin
				if (irq_any) begin
					// vector n at 4*(n+1)
					s_d.pc = VECTOR_STEP * (PC_W'(irq_idx) + 1'b1);
					s_d.ack[irq_idx] = 1'b1;
				end else if (req_in.valid) begin
					case (req_in.op)
						PSQ_OP_STEP: begin
							s_d.pc = pc_inc;
						end
						PSQ_OP_DIRECT: begin
							s_d.pc = req_in.addr;
						end
						PSQ_OP_FAR, PSQ_OP_CALL: begin
							// page picks one 2K slice of eight
							s_d.pc = {s_q.page_reg[PAGE_W-1:0],
								req_in.addr[OFS_W-1:0]};
						end
						PSQ_OP_BRANCH: begin
							if (req_in.taken) begin
								s_d.pc = {s_q.pc[PC_W-1:OFS_W],
									req_in.addr[OFS_W-1:0]};
							end else begin
								s_d.pc = pc_inc;
							end
						end
						PSQ_OP_RET: begin
							s_d.pc = top.pc;
						end
						PSQ_OP_RETSEL: begin
							s_d.pc = top.pc;
							s_d.rctx = top;
							s_d.rsel = req_in.sel;
							s_d.rvalid = 1'b1;
							if (req_in.sel[SEL_ROMP]) begin
								s_d.page_reg = {1'b0, top.rom_page_select};
							end
						end
						PSQ_OP_TABLE: begin
							s_d.tab_addr = tab_now;
							s_d.tab_pend = 1'b1;
							s_d.pc = pc_inc;
						end
						default: begin
							s_d.pc = s_q.pc;
						end
					endcase
				end
				// page register written, reserved bit dropped
				if (req_in.valid && req_in.page_wr) begin
					s_d.page_reg = {1'b0, req_in.page_data[PAGE_W-1:0]};
				end
			end
			default: begin
				s_d.st = ST_RESET;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_q <= '{st: ST_RESET, pc: RESET_VECTOR, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// context stack
	psq_stack u_stack (
		.mclk_in      (mclk_in),
		.rst_n_in     (rst_n_in),
		.push_in      (push),
		.pop_in       (pop),
		.push_data_in (push_ctx),
		.top_out      (top)
	);

	// rom address: table word index during a table fetch, else pc
	assign rom_addr_out = s_q.tab_pend ? s_q.tab_addr[TAB_W-1:2]
		: s_q.pc;
	assign table_addr_out = s_q.tab_addr;
	assign table_data_out = s_q.tab_data;
	assign table_data_valid_out = s_q.tab_valid;
	assign irq_ack_out = s_q.ack;
	assign restore_ctx_out = s_q.rctx;
	assign restore_sel_out = s_q.rsel;
	assign restore_valid_out = s_q.rvalid;
	// internal use only; the register has no software read path
	assign rom_page_out = s_q.page_reg[PAGE_W-1:0];
	assign pc_out = s_q.pc;
endmodule
`default_nettype wire

// [design/psq_pkg.sv]
`default_nettype none
package psq_pkg;
	// program counter and memory geometry
	localparam int PC_W        = 14;
	localparam int INSN_W      = 16;
	localparam int PAGE_W      = 3;
	localparam int OFS_W       = 11;
	localparam int NIB_W       = 4;
	localparam int TAB_W       = 16;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W        = 4;
	localparam int NUM_IRQ     = 8;
	localparam int SEL_W       = 8;
	localparam int RAM_PAGE_W  = 3;

	// vector addresses
	localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;
	localparam logic [PC_W-1:0] VECTOR_STEP  = 14'h0004;
	localparam logic [PC_W-1:0] CODE_START   = 14'h0024;

	// selective return bit positions
	localparam int SEL_TAB   = 0;
	localparam int SEL_BANK  = 1;
	localparam int SEL_WRP   = 2;
	localparam int SEL_ROMP  = 3;
	localparam int SEL_RAMP  = 4;
	localparam int SEL_ACC   = 5;
	localparam int SEL_CARRY = 6;

	// sequencing operation requested by the decoder
	typedef enum logic [3:0] {
		PSQ_OP_STEP = 4'h0, // increment
		PSQ_OP_DIRECT = 4'h1, // all 14 bits from instruction
		PSQ_OP_FAR = 4'h2, // jump via page register
		PSQ_OP_CALL = 4'h3, // call via page register
		PSQ_OP_BRANCH = 4'h4, // same-page branch/skip
		PSQ_OP_RET = 4'h5, // plain return
		PSQ_OP_RETSEL = 4'h6, // selective return
		PSQ_OP_TABLE = 4'h7, // table element read
		PSQ_OP_HOLD = 4'h8  // hold pc
	} psq_op_t;

	// context saved on the stack: 14+16+2+4+4+3+3+4+1 = 51 bits,
	// the high bank register keeps only its two significant bits
	typedef struct packed {
		logic [PC_W-1:0]  pc;
		logic [NIB_W-1:0] table_addr_nibble3;
		logic [NIB_W-1:0] table_addr_nibble2;
		logic [NIB_W-1:0] table_addr_nibble1;
		logic [NIB_W-1:0] table_addr_nibble0;
		logic [1:0]       data_bank_high;
		logic [NIB_W-1:0] data_bank_low;
		logic [NIB_W-1:0] work_register_page;
		logic [PAGE_W-1:0] rom_page_select;
		logic [RAM_PAGE_W-1:0] ram_page;
		logic [NIB_W-1:0] result_nibble_register;
		logic             carry_flag;
	} psq_ctx_t;

	localparam int CTX_W = $bits(psq_ctx_t);

	// decoder request into the sequencer
	typedef struct packed {
		logic              valid;
		psq_op_t           op;
		logic [PC_W-1:0]   addr;
		logic              taken;
		logic [SEL_W-1:0]  sel;
		logic              page_wr;
		logic [NIB_W-1:0]  page_data;
	} psq_req_t;
endpackage
`default_nettype wire

// [design/psq_stack.sv]
`default_nettype none
module psq_stack #(
	parameter int DEPTH = psq_pkg::STACK_DEPTH,
	parameter int AW    = psq_pkg::SP_W
) (
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// push and pop strobes
	input  wire logic              push_in,
	input  wire logic              pop_in,
	input  wire psq_pkg::psq_ctx_t push_data_in,
	// top of stack
	output psq_pkg::psq_ctx_t      top_out
);
	import psq_pkg::*;

	typedef struct packed {
		logic [AW-1:0] ptr;
		psq_ctx_t [DEPTH-1:0] mem;
	} psq_stk_state_t;

	psq_stk_state_t s_q;
	psq_stk_state_t s_d;

	// circular buffer: pushes past the depth overwrite the oldest entry
	always_comb begin
		s_d = s_q;
		if (push_in) begin
			s_d.mem[s_q.ptr] = push_data_in;
			s_d.ptr = s_q.ptr + 1'b1;
		end else if (pop_in) begin
			s_d.ptr = s_q.ptr - 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign top_out = s_q.mem[s_q.ptr - 1'b1];
endmodule
`default_nettype wire

// [test/psq_sequencer_props.sv]
`default_nettype none
module psq_sequencer_props (
	// clock, reset and requests
	input wire logic              mclk_in,
	input wire logic              rst_n_in,
	input wire psq_pkg::psq_req_t req_in,
	input wire psq_pkg::psq_ctx_t core_ctx_in,
	input wire logic [7:0]        irq_req_in,
	// rom and table
	input wire logic [13:0]       rom_addr_out,
	input wire logic [15:0]       rom_data_in,
	input wire logic [15:0]       table_addr_out,
	input wire logic [3:0]        table_data_out,
	input wire logic              table_data_valid_out,
	// acknowledge, restore, page and counter
	input wire logic [7:0]        irq_ack_out,
	input wire psq_pkg::psq_ctx_t restore_ctx_out,
	input wire logic [7:0]        restore_sel_out,
	input wire logic              restore_valid_out,
	input wire logic [2:0]        rom_page_out,
	input wire logic [13:0]       pc_out
);
	import psq_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	logic        run_q;
	logic        take;
	logic [15:0] tab_now;
	// a request counts once the reset entry cycle is over and no irq wins
	always_ff @(posedge mclk_in) run_q <= rst_n_in;
	assign take = run_q && irq_req_in == 8'h00 && req_in.valid;
	assign tab_now = {core_ctx_in.table_addr_nibble3,
		core_ctx_in.table_addr_nibble2, core_ctx_in.table_addr_nibble1,
		core_ctx_in.table_addr_nibble0};
	// vector of a one-hot acknowledge
	function automatic logic [13:0] vec_of(input logic [7:0] a);
		vec_of = 14'h0000;
		for (int i = 0; i < 8; i++)
			if (a[i])
				vec_of = 14'(4 * (i + 1));
	endfunction
	property p_boot;
		disable iff (1'b0) $rose(rst_n_in) |->
			pc_out == RESET_VECTOR ##1 pc_out == RESET_VECTOR;
	endproperty
	property p_prio;
		run_q && irq_req_in != 8'h00 |=> irq_ack_out ==
			($past(irq_req_in) & (~$past(irq_req_in) + 8'h01));
	endproperty
	property p_vec;
		irq_ack_out != 8'h00 |-> pc_out == vec_of(irq_ack_out);
	endproperty
	property p_step;
		take && req_in.op == PSQ_OP_STEP |=> pc_out == $past(pc_out) + 14'h1;
	endproperty
	property p_direct;
		take && req_in.op == PSQ_OP_DIRECT |=> pc_out == $past(req_in.addr);
	endproperty
	property p_far;
		take && (req_in.op == PSQ_OP_CALL || req_in.op == PSQ_OP_FAR) |=>
			pc_out == {$past(rom_page_out), $past(req_in.addr[10:0])};
	endproperty
	property p_branch;
		take && req_in.op == PSQ_OP_BRANCH && req_in.taken |=>
			pc_out == {$past(pc_out[13:11]), $past(req_in.addr[10:0])};
	endproperty
	property p_page;
		run_q && req_in.valid && req_in.page_wr |=>
			rom_page_out == $past(req_in.page_data[2:0]);
	endproperty
	property p_retsel;
		take && req_in.op == PSQ_OP_RETSEL |=>
			restore_valid_out && restore_sel_out == $past(req_in.sel);
	endproperty
	property p_table;
		take && req_in.op == PSQ_OP_TABLE |=>
			rom_addr_out == $past(tab_now[15:2]) ##1 table_data_valid_out &&
			table_data_out == 4'($past(rom_data_in) >>
			{$past(tab_now[1:0], 2), 2'b00});
	endproperty
	a_boot: assert property (p_boot) else $error("bad reset pc");
	a_prio: assert property (p_prio) else $error("bad irq pick");
	a_vec: assert property (p_vec) else $error("bad vector");
	a_step: assert property (p_step) else $error("bad step");
	a_direct: assert property (p_direct) else $error("bad jump");
	a_far: assert property (p_far) else $error("bad call");
	a_branch: assert property (p_branch) else $error("bad branch");
	a_page: assert property (p_page) else $error("bad page");
	a_retsel: assert property (p_retsel) else $error("bad return");
	a_table: assert property (p_table) else $error("bad table");
	// main scenarios reached
	c_call: cover property (take && req_in.op == PSQ_OP_CALL);
	c_irq: cover property (irq_ack_out != 8'h00);
	c_tab: cover property (table_data_valid_out);
endmodule
bind psq_sequencer psq_sequencer_props u_props (
	.mclk_in              (mclk_in),
	.rst_n_in             (rst_n_in),
	.req_in               (req_in),
	.core_ctx_in          (core_ctx_in),
	.irq_req_in           (irq_req_in),
	.rom_addr_out         (rom_addr_out),
	.rom_data_in          (rom_data_in),
	.table_addr_out       (table_addr_out),
	.table_data_out       (table_data_out),
	.table_data_valid_out (table_data_valid_out),
	.irq_ack_out          (irq_ack_out),
	.restore_ctx_out      (restore_ctx_out),
	.restore_sel_out      (restore_sel_out),
	.restore_valid_out    (restore_valid_out),
	.rom_page_out         (rom_page_out),
	.pc_out               (pc_out)
);
`default_nettype wire

// [test/psq_rom_model.sv]
`default_nettype none
module psq_rom_model (
	// clock and reset
	input wire logic        mclk_in,
	input wire logic        rst_n_in,
	// program rom
	input wire logic [13:0] addr_in,
	output logic [15:0]     data_out,
	// interrupt sources
	input wire logic [7:0]  raise_in,
	input wire logic [7:0]  ack_in,
	output logic [7:0]      irq_out
);
	logic [7:0] pend_q;
	// word pattern tied to its address so a wrong fetch shows
	assign data_out = {addr_in, 2'b01} ^ 16'h9c3a;
	// a source holds its request until acknowledged, then drops at once
	always_ff @(posedge mclk_in)
		pend_q <= rst_n_in ? (pend_q | raise_in) & ~ack_in : 8'h00;
	assign irq_out = pend_q & ~ack_in;
endmodule
`default_nettype wire

// [test/psq_sequencer_tb.sv]
`default_nettype none
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin \
	err_total++; $display("wrong value %s exp %h got %h", n, e, v); end end
module psq_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import psq_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	psq_req_t    req = '0;
	psq_ctx_t    ctx = '{14'h0, 4'h1, 4'h2, 4'h3, 4'h6, 2'h2, 4'h9, 4'ha,
		3'h0, 3'h4, 4'h7, 1'b1};
	psq_ctx_t    ctx_call, res_ctx;
	logic [7:0]  raise = 8'h00, irq, ack, res_sel;
	logic [13:0] rom_a, pc;
	logic [15:0] rom_d, tab_a;
	logic [3:0]  tab_d;
	logic [2:0]  page;
	logic        tab_v, res_v;
	int          err_total = 0, comparisons = 0, cycles = 0;
	psq_sequencer dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req),
		.core_ctx_in(ctx), .irq_req_in(irq), .rom_addr_out(rom_a),
		.rom_data_in(rom_d), .table_addr_out(tab_a), .table_data_out(tab_d),
		.table_data_valid_out(tab_v), .irq_ack_out(ack),
		.restore_ctx_out(res_ctx), .restore_sel_out(res_sel),
		.restore_valid_out(res_v), .rom_page_out(page), .pc_out(pc));
	psq_rom_model far_side (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.addr_in(rom_a), .data_out(rom_d), .raise_in(raise), .ack_in(ack),
		.irq_out(irq));
	// clock and hang guard
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	// one decoder request for one edge; hold also writes the page
	task automatic issue(input psq_op_t op, input logic [13:0] a,
		input logic [7:0] s, input logic [3:0] p);
		tick(1);
		req = '{1'b1, op, a, 1'b1, s, op == PSQ_OP_HOLD, p};
		tick(1);
		req.valid = 1'b0;
	endtask
	// raise sources, check the vector taken two edges later
	task automatic irq_go(input logic [7:0] m, input logic [13:0] v);
		tick(1);
		raise = m;
		tick(1);
		raise = 8'h00;
		tick(1);
		`CHK("vector", v, pc)
	endtask
	initial begin
		tick(2);
		rst_n_in = 1'b1;
		tick(1);
		`CHK("pc", 14'h0000, pc)
		issue(PSQ_OP_DIRECT, 14'h3fff, 8'h00, 4'h0);
		`CHK("pc", 14'h3fff, pc)
		issue(PSQ_OP_STEP, 14'h0, 8'h00, 4'h0);
		`CHK("pc", 14'h0000, pc)
		issue(PSQ_OP_DIRECT, CODE_START, 8'h00, 4'h0);
		issue(PSQ_OP_HOLD, 14'h0, 8'h00, 4'hd);
		`CHK("page", 3'h5, page)
		ctx_call = ctx;
		issue(PSQ_OP_CALL, 14'h3923, 8'h00, 4'h0);
		`CHK("pc", 14'h2923, pc)
		issue(PSQ_OP_BRANCH, 14'h07ff, 8'h00, 4'h0);
		`CHK("pc", 14'h2fff, pc)
		issue(PSQ_OP_FAR, 14'h0456, 8'h00, 4'h0);
		`CHK("pc", 14'h2c56, pc)
		ctx = ~ctx_call;
		issue(PSQ_OP_HOLD, 14'h0, 8'h00, 4'h2);
		issue(PSQ_OP_RETSEL, 14'h0, 8'h7f, 4'h0);
		ctx_call.pc = 14'h0025;
		ctx_call.rom_page_select = 3'h5;
		`CHK("pc", 14'h0025, pc)
		`CHK("valid", 1'b1, res_v)
		`CHK("context", ctx_call, res_ctx)
		`CHK("select", 8'h7f, res_sel)
		`CHK("page", 3'h5, page)
		for (int i = 0; i < 17; i++)
			issue(PSQ_OP_CALL, 14'(i), 8'h00, 4'h0);
		issue(PSQ_OP_HOLD, 14'h0, 8'h00, 4'h1);
		for (int i = 16; i > 0; i--) begin
			issue(PSQ_OP_RET, 14'h0, 8'h00, 4'h0);
			`CHK("pc", 14'h2800 + 14'(i), pc)
		end
		`CHK("page", 3'h1, page)
		for (int k = 0; k < 8; k++) begin
			irq_go(8'h01 << k, 14'(4 * (k + 1)));
			`CHK("ack", 8'h01 << k, ack)
			issue(PSQ_OP_RET, 14'h0, 8'h00, 4'h0);
			`CHK("pc", 14'h2801, pc)
		end
		irq_go(8'h48, 14'h0010);
		tick(1);
		`CHK("pc", 14'h001c, pc)
		issue(PSQ_OP_RET, 14'h0, 8'h00, 4'h0);
		issue(PSQ_OP_RET, 14'h0, 8'h00, 4'h0);
		`CHK("pc", 14'h2801, pc)
		ctx = ctx_call;
		issue(PSQ_OP_TABLE, 14'h0, 8'h00, 4'h0);
		`CHK("word", 14'h048d, rom_a)
		`CHK("table address", 16'h1236, tab_a)
		tick(1);
		`CHK("valid", 1'b1, tab_v)
		`CHK("element", 4'(({14'h048d, 2'b01} ^ 16'h9c3a) >> 8), tab_d)
		give_verdict();
	end
endmodule
`default_nettype wire
